// file: core/ipm_pkg.sv
// Package for the inactivity power manager: register map, fields, types and timing
// Behaviour
// - Power management disabled freezes settings except awareness flag and event mask, and holds the state at full on
// - Keep OS power-interface awareness flag, default no
// - Button toggles suspend, or power on/off
// - Monitor enters standby, suspend or off
// - Video enters selected standby or suspend state after matching period; off is never entered
// - Disk enters selected low-power state on timeout
// - Disk timeout disabled or 1 to 15 minutes
// - Timer unit 32s, 4ms, 4min or 4s
// - Default timer unit is 4 minutes
// - Full on enters standby after standby period
// - Period values are multiples of unit, or disabled
// - Standby enters suspend after suspend period
// - Standby slows processor clock by selected band
// - Monitored display activity wakes and restarts timers
// - Monitored device interrupt wakes and restarts timers
// - Device index map, each defaults to ignore
package ipm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BASE_TICK_NS = 4000000;
    localparam int unsigned BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
    // Unit lengths counted in 4 ms base ticks
    localparam int unsigned TICKS_4S = 1000;
    localparam int unsigned TICKS_32S = 8000;
    localparam int unsigned TICKS_4MIN = 60000;
    localparam int unsigned TICKS_1MIN = 15000;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_DEVMON = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_EVT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;

    localparam int unsigned NUM_DEV = 9;
    localparam logic [8:0] DEVMON_VALID = 9'h1EF;
    localparam int unsigned NUM_EVT = 5;
    localparam int unsigned EVT_STANDBY = 0;
    localparam int unsigned EVT_SUSPEND = 1;
    localparam int unsigned EVT_WAKE = 2;
    localparam int unsigned EVT_HDD = 3;
    localparam int unsigned EVT_BUTTON = 4;

    typedef enum logic [1:0] {
        IPM_PS_ON = 2'b00,
        IPM_PS_STANDBY = 2'b01,
        IPM_PS_SUSPEND = 2'b10,
        IPM_PS_OFF = 2'b11
    } ipm_pstate_t;
    typedef enum logic [1:0] {
        IPM_UNIT_32S = 2'b00,
        IPM_UNIT_4MS = 2'b01,
        IPM_UNIT_4MIN = 2'b10,
        IPM_UNIT_4S = 2'b11
    } ipm_unit_t;
    typedef enum logic [1:0] {
        IPM_LP_DISABLED = 2'b00,
        IPM_LP_STANDBY = 2'b01,
        IPM_LP_SUSPEND = 2'b10,
        IPM_LP_OFF = 2'b11
    } ipm_lp_t;
    typedef enum logic [1:0] {
        IPM_SAVE_POS = 2'b00,
        IPM_SAVE_SLEEP = 2'b01,
        IPM_SAVE_STOPCLK = 2'b10,
        IPM_SAVE_DEEP = 2'b11
    } ipm_save_t;

    // Control register layout, msb first; bits 31:21 read zero
    typedef struct packed {
        logic disp_mon;
        logic [2:0] slow_ratio;
        ipm_unit_t unit;
        ipm_save_t save_type;
        logic [3:0] hdd_timeout;
        ipm_lp_t hdd_mode;
        ipm_lp_t video_mode;
        ipm_lp_t monitor_mode;
        logic button_suspend;
        logic os_aware;
        logic pm_enable;
    } ipm_ctrl_t;
    localparam int unsigned CTRL_W = 21;
    localparam int unsigned CTRL_OS_AWARE_BIT = 1;
    localparam ipm_ctrl_t CTRL_RESET = '{disp_mon: 1'b0, slow_ratio: 3'h4, unit: IPM_UNIT_4MIN,
        save_type: IPM_SAVE_POS, hdd_timeout: 4'h0, hdd_mode: IPM_LP_DISABLED,
        video_mode: IPM_LP_DISABLED, monitor_mode: IPM_LP_STANDBY, button_suspend: 1'b0,
        os_aware: 1'b0, pm_enable: 1'b0};
    localparam int unsigned TO_STBY_LSB = 0;
    localparam int unsigned TO_SUSP_LSB = 8;
    localparam int unsigned TO_W = 7;

    // Power-control outputs to the rest of the board
    typedef struct packed {
        ipm_pstate_t pstate;
        logic clk_slow;
        logic [2:0] slow_ratio;
        ipm_save_t save_type;
        ipm_lp_t monitor;
        ipm_lp_t video;
        ipm_lp_t hdd;
        logic os_aware;
    } ipm_out_t;
endpackage : ipm_pkg

// file: core/ipm_power_manager.sv
// Inactivity power manager: APB registers, inactivity timers and power-state machine
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ipm_power_manager #(
    parameter int unsigned P_BASE_TICK_CYC = ipm_pkg::BASE_TICK_CYC,
    parameter int unsigned P_TICKS_4S = ipm_pkg::TICKS_4S,
    parameter int unsigned P_TICKS_32S = ipm_pkg::TICKS_32S,
    parameter int unsigned P_TICKS_4MIN = ipm_pkg::TICKS_4MIN,
    parameter int unsigned P_TICKS_1MIN = ipm_pkg::TICKS_1MIN
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_display_act,
    input wire logic [8:0] i_dev_irq,
    input wire logic i_button,
    output ipm_pkg::ipm_out_t o_pm,
    output logic o_irq
);
    ipm_pkg::ipm_ctrl_t ctrl_ff, nxt_ctrl;
    logic [15:0] to_ff, nxt_to;
    logic [8:0] devmon_ff, nxt_devmon;
    logic [4:0] evt_ff, nxt_evt;
    logic [4:0] mask_ff, nxt_mask;
    logic [31:0] rdata_ff, nxt_rdata;
    logic slverr_ff, nxt_slverr;
    ipm_pkg::ipm_pstate_t pstate_ff, nxt_pstate;
    logic [18:0] base_ff, nxt_base;
    logic [15:0] unit_ff, nxt_unit;
    logic [15:0] min_ff, nxt_min;
    logic [6:0] idle_ff, nxt_idle;
    logic [3:0] hdd_min_ff, nxt_hdd_min;
    logic hdd_low_ff, nxt_hdd_low;
    ipm_pkg::ipm_out_t out_ff, nxt_out;

    logic setup_ph, access_ph, wr_acc, rd_acc, addr_ok;
    logic base_tick, unit_tick, min_tick;
    logic [15:0] unit_len;
    logic [6:0] stby_n, susp_n;
    logic [8:0] dev_hit;
    logic wake_act, hdd_act;
    logic [4:0] evt_set;

    // APB: read data is captured in the setup cycle, so the access phase never waits
    assign setup_ph = i_psel & ~i_penable;
    assign access_ph = i_psel & i_penable;
    assign wr_acc = access_ph & i_pwrite & ~slverr_ff;
    assign rd_acc = access_ph & ~i_pwrite;
    assign o_pready = access_ph;
    assign o_pslverr = access_ph & slverr_ff;
    assign o_prdata = rdata_ff;
    assign o_pm = out_ff;
    assign o_irq = |(evt_ff & mask_ff);

    always_comb begin
        addr_ok = (i_paddr == ipm_pkg::OFS_CTRL) || (i_paddr == ipm_pkg::OFS_TIMEOUT) ||
                  (i_paddr == ipm_pkg::OFS_DEVMON) || (i_paddr == ipm_pkg::OFS_STATUS) ||
                  (i_paddr == ipm_pkg::OFS_EVT) || (i_paddr == ipm_pkg::OFS_MASK);
        nxt_slverr = setup_ph ? ~addr_ok : slverr_ff;
        nxt_rdata = rdata_ff;
        if (setup_ph) begin
            unique case (i_paddr)
                ipm_pkg::OFS_CTRL: nxt_rdata = {11'h000, ctrl_ff};
                ipm_pkg::OFS_TIMEOUT: nxt_rdata = {16'h0000, to_ff};
                ipm_pkg::OFS_DEVMON: nxt_rdata = {23'h000000, devmon_ff};
                ipm_pkg::OFS_STATUS: nxt_rdata = {23'h000000, hdd_low_ff, out_ff.video, out_ff.monitor,
                                                  out_ff.clk_slow, out_ff.os_aware, pstate_ff};
                ipm_pkg::OFS_EVT: nxt_rdata = {27'h0000000, evt_ff};
                ipm_pkg::OFS_MASK: nxt_rdata = {27'h0000000, mask_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // Configuration registers
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_to = to_ff;
        nxt_devmon = devmon_ff;
        nxt_mask = mask_ff;
        if (wr_acc) begin
            unique case (i_paddr)
                ipm_pkg::OFS_CTRL: begin
                    if (ctrl_ff.pm_enable) begin
                        nxt_ctrl = ipm_pkg::ipm_ctrl_t'(i_pwdata[ipm_pkg::CTRL_W-1:0]);
                    end else begin
                        // Only the enable and the awareness flag may change while disabled
                        nxt_ctrl.pm_enable = i_pwdata[0];
                        nxt_ctrl.os_aware = i_pwdata[ipm_pkg::CTRL_OS_AWARE_BIT];
                    end
                end
                ipm_pkg::OFS_TIMEOUT: begin
                    if (ctrl_ff.pm_enable) begin
                        nxt_to = {1'b0, i_pwdata[ipm_pkg::TO_SUSP_LSB +: ipm_pkg::TO_W],
                                  1'b0, i_pwdata[ipm_pkg::TO_STBY_LSB +: ipm_pkg::TO_W]};
                    end
                end
                ipm_pkg::OFS_DEVMON: begin
                    if (ctrl_ff.pm_enable) begin
                        nxt_devmon = i_pwdata[8:0] & ipm_pkg::DEVMON_VALID;
                    end
                end
                ipm_pkg::OFS_MASK: nxt_mask = i_pwdata[ipm_pkg::NUM_EVT-1:0];
                default: nxt_mask = mask_ff;
            endcase
        end
    end

    // Time base: 4 ms ticks, then the selected unit and a minute for the disk
    always_comb begin
        unique case (ctrl_ff.unit)
            ipm_pkg::IPM_UNIT_32S: unit_len = P_TICKS_32S[15:0];
            ipm_pkg::IPM_UNIT_4MS: unit_len = 16'h0001;
            ipm_pkg::IPM_UNIT_4MIN: unit_len = P_TICKS_4MIN[15:0];
            ipm_pkg::IPM_UNIT_4S: unit_len = P_TICKS_4S[15:0];
        endcase
        base_tick = (base_ff == 19'(P_BASE_TICK_CYC - 1));
        nxt_base = base_tick ? 19'h00000 : base_ff + 19'h00001;
        unit_tick = base_tick && (unit_ff >= unit_len - 16'h0001);
        nxt_unit = unit_tick ? 16'h0000 : (base_tick ? unit_ff + 16'h0001 : unit_ff);
        min_tick = base_tick && (min_ff == 16'(P_TICKS_1MIN - 1));
        nxt_min = min_tick ? 16'h0000 : (base_tick ? min_ff + 16'h0001 : min_ff);
    end

    // Activity detection per monitored device line
    genvar g;
    generate
        for (g = 0; g < ipm_pkg::NUM_DEV; g++) begin : g_dev
            assign dev_hit[g] = i_dev_irq[g] & devmon_ff[g];
        end
    endgenerate
    assign wake_act = (i_display_act & ctrl_ff.disp_mon) | (|dev_hit);
    assign hdd_act = |i_dev_irq[3:0];
    // Field n stands for n units: 32..4064 s in 32 s steps, or 4..508 in steps of 4
    assign stby_n = to_ff[ipm_pkg::TO_STBY_LSB +: ipm_pkg::TO_W];
    assign susp_n = to_ff[ipm_pkg::TO_SUSP_LSB +: ipm_pkg::TO_W];

    // Power-state machine and inactivity counter
    always_comb begin
        nxt_pstate = pstate_ff;
        nxt_idle = idle_ff;
        evt_set = 5'h00;
        if (!ctrl_ff.pm_enable) begin
            nxt_pstate = ipm_pkg::IPM_PS_ON;
            nxt_idle = 7'h00;
        end else if (i_button) begin
            nxt_idle = 7'h00;
            evt_set[ipm_pkg::EVT_BUTTON] = 1'b1;
            if (ctrl_ff.button_suspend) begin
                nxt_pstate = (pstate_ff == ipm_pkg::IPM_PS_ON) ? ipm_pkg::IPM_PS_SUSPEND : ipm_pkg::IPM_PS_ON;
            end else begin
                nxt_pstate = (pstate_ff == ipm_pkg::IPM_PS_OFF) ? ipm_pkg::IPM_PS_ON : ipm_pkg::IPM_PS_OFF;
            end
        end else if (wake_act) begin
            // Any monitored activity restarts both timers
            nxt_idle = 7'h00;
            if (pstate_ff == ipm_pkg::IPM_PS_STANDBY || pstate_ff == ipm_pkg::IPM_PS_SUSPEND) begin
                nxt_pstate = ipm_pkg::IPM_PS_ON;
                evt_set[ipm_pkg::EVT_WAKE] = 1'b1;
            end
        end else if (unit_tick) begin
            unique case (pstate_ff)
                ipm_pkg::IPM_PS_ON: begin
                    if (stby_n != 7'h00 && idle_ff + 7'h01 >= stby_n) begin
                        nxt_pstate = ipm_pkg::IPM_PS_STANDBY;
                        nxt_idle = 7'h00;
                        evt_set[ipm_pkg::EVT_STANDBY] = 1'b1;
                    end else if (idle_ff != 7'h7F) begin
                        nxt_idle = idle_ff + 7'h01;
                    end
                end
                ipm_pkg::IPM_PS_STANDBY: begin
                    if (susp_n != 7'h00 && idle_ff + 7'h01 >= susp_n) begin
                        nxt_pstate = ipm_pkg::IPM_PS_SUSPEND;
                        nxt_idle = 7'h00;
                        evt_set[ipm_pkg::EVT_SUSPEND] = 1'b1;
                    end else if (idle_ff != 7'h7F) begin
                        nxt_idle = idle_ff + 7'h01;
                    end
                end
                ipm_pkg::IPM_PS_SUSPEND: nxt_idle = idle_ff;
                ipm_pkg::IPM_PS_OFF: nxt_idle = idle_ff;
            endcase
        end
    end

    // Disk inactivity in whole minutes
    always_comb begin
        nxt_hdd_min = hdd_min_ff;
        nxt_hdd_low = hdd_low_ff;
        if (!ctrl_ff.pm_enable || hdd_act || ctrl_ff.hdd_mode == ipm_pkg::IPM_LP_DISABLED
            || ctrl_ff.hdd_timeout == 4'h0) begin
            nxt_hdd_min = 4'h0;
            nxt_hdd_low = 1'b0;
        end else if (min_tick && !hdd_low_ff) begin
            if (hdd_min_ff + 4'h1 >= ctrl_ff.hdd_timeout) begin
                nxt_hdd_low = 1'b1;
            end
            nxt_hdd_min = hdd_min_ff + 4'h1;
        end
    end

    // Outputs, registered from next-state values so they follow the state the same edge
    always_comb begin
        nxt_out.pstate = nxt_pstate;
        nxt_out.clk_slow = (nxt_pstate == ipm_pkg::IPM_PS_STANDBY);
        nxt_out.slow_ratio = nxt_ctrl.slow_ratio;
        nxt_out.save_type = nxt_ctrl.save_type;
        nxt_out.os_aware = nxt_ctrl.os_aware;
        nxt_out.monitor = ipm_pkg::IPM_LP_DISABLED;
        if (nxt_pstate == ipm_pkg::IPM_PS_STANDBY && nxt_ctrl.monitor_mode == ipm_pkg::IPM_LP_STANDBY) begin
            nxt_out.monitor = ipm_pkg::IPM_LP_STANDBY;
        end else if (nxt_pstate == ipm_pkg::IPM_PS_SUSPEND) begin
            nxt_out.monitor = nxt_ctrl.monitor_mode;
        end
        nxt_out.video = ipm_pkg::IPM_LP_DISABLED;
        if (nxt_pstate == ipm_pkg::IPM_PS_STANDBY && nxt_ctrl.video_mode == ipm_pkg::IPM_LP_STANDBY) begin
            nxt_out.video = ipm_pkg::IPM_LP_STANDBY;
        end else if (nxt_pstate == ipm_pkg::IPM_PS_SUSPEND && nxt_ctrl.video_mode != ipm_pkg::IPM_LP_OFF) begin
            nxt_out.video = nxt_ctrl.video_mode;
        end
        // A cleared timeout releases the disk at once, not one cycle later
        nxt_out.hdd = ipm_pkg::IPM_LP_DISABLED;
        if (nxt_hdd_low && nxt_ctrl.hdd_timeout != 4'h0) begin
            nxt_out.hdd = nxt_ctrl.hdd_mode;
        end
    end

    // Sticky events: a read clears only the bits it reported in its setup cycle,
    // so an event that lands between setup and access is kept for the next read
    always_comb begin
        nxt_evt = evt_ff;
        if (rd_acc && i_paddr == ipm_pkg::OFS_EVT) begin
            nxt_evt = evt_ff & ~rdata_ff[ipm_pkg::NUM_EVT-1:0];
        end
        nxt_evt = nxt_evt | evt_set | {1'b0, nxt_hdd_low & ~hdd_low_ff, 3'b000};
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= ipm_pkg::CTRL_RESET;
            to_ff <= 16'h0000;
            devmon_ff <= 9'h000;
            mask_ff <= 5'h00;
            evt_ff <= 5'h00;
            rdata_ff <= 32'h00000000;
            slverr_ff <= 1'b0;
            pstate_ff <= ipm_pkg::IPM_PS_ON;
            base_ff <= 19'h00000;
            unit_ff <= 16'h0000;
            min_ff <= 16'h0000;
            idle_ff <= 7'h00;
            hdd_min_ff <= 4'h0;
            hdd_low_ff <= 1'b0;
            out_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            to_ff <= nxt_to;
            devmon_ff <= nxt_devmon;
            mask_ff <= nxt_mask;
            evt_ff <= nxt_evt;
            rdata_ff <= nxt_rdata;
            slverr_ff <= nxt_slverr;
            pstate_ff <= nxt_pstate;
            base_ff <= nxt_base;
            unit_ff <= nxt_unit;
            min_ff <= nxt_min;
            idle_ff <= nxt_idle;
            hdd_min_ff <= nxt_hdd_min;
            hdd_low_ff <= nxt_hdd_low;
            out_ff <= nxt_out;
        end
    end

    property p_frozen;
        @(posedge i_clock) disable iff (!i_arst_n)
        !ctrl_ff.pm_enable |=> pstate_ff == ipm_pkg::IPM_PS_ON;
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while disabled");

    property p_locked_write;
        @(posedge i_clock) disable iff (!i_arst_n)
        wr_acc && i_paddr == ipm_pkg::OFS_CTRL && !ctrl_ff.pm_enable
        |=> ctrl_ff.os_aware == $past(i_pwdata[1]) && ctrl_ff.unit == $past(ctrl_ff.unit)
            && ctrl_ff.hdd_mode == $past(ctrl_ff.hdd_mode);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked setting changed");

    property p_button_off;
        @(posedge i_clock) disable iff (!i_arst_n)
        ctrl_ff.pm_enable && i_button && !ctrl_ff.button_suspend && pstate_ff != ipm_pkg::IPM_PS_OFF
        |=> pstate_ff == ipm_pkg::IPM_PS_OFF && o_pm.pstate == ipm_pkg::IPM_PS_OFF;
    endproperty
    a_button_off: assert property (p_button_off) else $error("button did not power off");

    property p_button_susp;
        @(posedge i_clock) disable iff (!i_arst_n)
        ctrl_ff.pm_enable && i_button && ctrl_ff.button_suspend && pstate_ff == ipm_pkg::IPM_PS_SUSPEND
        |=> pstate_ff == ipm_pkg::IPM_PS_ON;
    endproperty
    a_button_susp: assert property (p_button_susp) else $error("button did not resume");

    property p_video;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_pm.video != ipm_pkg::IPM_LP_DISABLED |-> o_pm.pstate != ipm_pkg::IPM_PS_ON
            && ctrl_ff.video_mode != ipm_pkg::IPM_LP_DISABLED;
    endproperty
    a_video: assert property (p_video) else $error("video saving while disabled");

    property p_hdd;
        @(posedge i_clock) disable iff (!i_arst_n)
        hdd_act |=> o_pm.hdd == ipm_pkg::IPM_LP_DISABLED && hdd_min_ff == 4'h0;
    endproperty
    a_hdd: assert property (p_hdd) else $error("disk stayed low after activity");

    property p_no_direct;
        @(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff == ipm_pkg::IPM_PS_ON && !i_button |=> pstate_ff != ipm_pkg::IPM_PS_SUSPEND;
    endproperty
    a_no_direct: assert property (p_no_direct) else $error("suspend entered from full on");

    property p_slow;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_pm.clk_slow |-> pstate_ff == ipm_pkg::IPM_PS_STANDBY && o_pm.slow_ratio == ctrl_ff.slow_ratio;
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock outside standby");

    property p_wake;
        @(posedge i_clock) disable iff (!i_arst_n)
        ctrl_ff.pm_enable && !i_button && wake_act
        && (pstate_ff == ipm_pkg::IPM_PS_STANDBY || pstate_ff == ipm_pkg::IPM_PS_SUSPEND)
        |=> pstate_ff == ipm_pkg::IPM_PS_ON && idle_ff == 7'h00 && evt_ff[ipm_pkg::EVT_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("activity did not wake");

    property p_disabled_timer;
        @(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff == ipm_pkg::IPM_PS_ON && stby_n == 7'h00 && !i_button |=> pstate_ff == ipm_pkg::IPM_PS_ON;
    endproperty
    a_disabled_timer: assert property (p_disabled_timer) else $error("disabled timer expired");

    property p_timer_locked;
        @(posedge i_clock) disable iff (!i_arst_n)
        wr_acc && i_paddr == ipm_pkg::OFS_TIMEOUT && !ctrl_ff.pm_enable |=> to_ff == $past(to_ff);
    endproperty
    a_timer_locked: assert property (p_timer_locked) else $error("timeout changed while disabled");

    property p_monitor;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_pm.pstate == ipm_pkg::IPM_PS_SUSPEND |-> o_pm.monitor == ctrl_ff.monitor_mode;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor state wrong in suspend");

    property p_hdd_timeout;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_pm.hdd != ipm_pkg::IPM_LP_DISABLED |-> ctrl_ff.hdd_timeout != 4'h0 && o_pm.hdd == ctrl_ff.hdd_mode;
    endproperty
    a_hdd_timeout: assert property (p_hdd_timeout) else $error("disk saving without a timeout");

    // Only a monitored line, the button or clearing pm_enable may bring the system back from standby
    property p_ignored;
        @(posedge i_clock) disable iff (!i_arst_n)
        ctrl_ff.pm_enable && !i_button && !wake_act && (i_dev_irq & ~devmon_ff) != 9'h000
        && pstate_ff == ipm_pkg::IPM_PS_STANDBY |=> pstate_ff != ipm_pkg::IPM_PS_ON;
    endproperty
    a_ignored: assert property (p_ignored) else $error("ignored device woke the system");

    c_standby: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff == ipm_pkg::IPM_PS_ON ##1 pstate_ff == ipm_pkg::IPM_PS_STANDBY);
    c_suspend: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff == ipm_pkg::IPM_PS_STANDBY ##1 pstate_ff == ipm_pkg::IPM_PS_SUSPEND);
    c_wake: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff == ipm_pkg::IPM_PS_SUSPEND ##1 pstate_ff == ipm_pkg::IPM_PS_ON);
    c_hdd: cover property (@(posedge i_clock) disable iff (!i_arst_n) !hdd_low_ff ##1 hdd_low_ff);
    c_power_off: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pstate_ff != ipm_pkg::IPM_PS_OFF ##1 pstate_ff == ipm_pkg::IPM_PS_OFF);
endmodule : ipm_power_manager
`default_nettype wire

// file: bench/ipm_testbench.sv
// Self-checking testbench for the inactivity power manager
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_clock, i_arst_n, i_psel, i_penable, i_pwrite, i_display_act, i_button;
    logic o_pready, o_pslverr, o_irq, rd_err;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd_data;
    logic [8:0] i_dev_irq;
    ipm_pkg::ipm_out_t o_pm;
    ipm_pkg::ipm_ctrl_t c;
    logic [7:0] regs [5] = '{ipm_pkg::OFS_TIMEOUT, ipm_pkg::OFS_DEVMON, ipm_pkg::OFS_STATUS,
        ipm_pkg::OFS_EVT, ipm_pkg::OFS_MASK};
    // Unit lengths in base ticks, matching the shortened parameters below
    int units [4] = '{3, 1, 5, 2};
    int err_count = 0;
    int samples_checked = 0;
    int cyc, t;

    ipm_power_manager #(.P_BASE_TICK_CYC(4), .P_TICKS_4S(2), .P_TICKS_32S(3), .P_TICKS_4MIN(5),
        .P_TICKS_1MIN(3)) dut_u (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_display_act(i_display_act), .i_dev_irq(i_dev_irq), .i_button(i_button), .o_pm(o_pm),
        .o_irq(o_irq));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (o_pready !== 1'b1) begin
            err_count++;
            end_sim();
        end
        rd_data = o_prdata;
        rd_err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // Early finish is allowed: the unit prescaler may already be part way through a unit
    task automatic wait_st(input logic hdd, input logic [1:0] exp, input int tgt, input int slack);
        for (cyc = 1; cyc < 3000; cyc++) begin
            @(posedge i_clock);
            #1;
            if ((hdd ? 2'(o_pm.hdd) : 2'(o_pm.pstate)) === exp) break;
        end
        if (cyc >= 3000) begin
            err_count++;
            end_sim();
        end
        chk((cyc >= tgt - slack && cyc <= tgt + 4) ? tgt : cyc, tgt);
    endtask : wait_st

    // One-cycle pulse on {button, display, device lines}
    task automatic pulse(input logic [10:0] v);
        @(posedge i_clock);
        {i_button, i_display_act, i_dev_irq} <= v;
        @(posedge i_clock);
        {i_button, i_display_act, i_dev_irq} <= 11'h000;
        #1;
    endtask : pulse

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    initial begin
        i_arst_n = 1'b0;
        {i_psel, i_penable, i_pwrite, i_button, i_display_act} = 5'h00;
        i_dev_irq = 9'h000;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        repeat (10) @(posedge i_clock);
        i_arst_n <= 1'b1;
        apb(1'b0, ipm_pkg::OFS_CTRL, 32'h0);
        chk(rd_data, {11'h000, ipm_pkg::CTRL_RESET});
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd_data, 32'h0);
        end
        // Disabled manager: only the awareness flag may change, button does nothing
        apb(1'b1, ipm_pkg::OFS_CTRL, ~{11'h000, ipm_pkg::CTRL_RESET} & 32'hFFFF_FFFE);
        apb(1'b1, ipm_pkg::OFS_TIMEOUT, 32'h0000_0101);
        pulse(11'h400);
        chk(32'(o_pm.pstate), 32'h0);
        chk(32'(o_pm.os_aware), 32'h1);
        apb(1'b0, ipm_pkg::OFS_CTRL, 32'h0);
        chk(rd_data, {11'h000, ipm_pkg::CTRL_RESET} | 32'h2);
        apb(1'b0, ipm_pkg::OFS_TIMEOUT, 32'h0);
        chk(rd_data, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        c = ipm_pkg::CTRL_RESET;
        c.pm_enable = 1'b1;
        c.monitor_mode = ipm_pkg::IPM_LP_OFF;
        c.video_mode = ipm_pkg::IPM_LP_SUSPEND;
        c.slow_ratio = 3'h6;
        c.disp_mon = 1'b1;
        c.save_type = ipm_pkg::IPM_SAVE_DEEP;
        apb(1'b1, ipm_pkg::OFS_MASK, 32'h0000_0004);
        // Timeouts can only be written once the manager is enabled
        apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
        apb(1'b1, ipm_pkg::OFS_TIMEOUT, 32'h0000_0102);
        for (int u = 0; u < 4; u++) begin
            c.unit = ipm_pkg::ipm_unit_t'(u);
            t = units[u] * 4;
            apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
            pulse(11'h200);
            wait_st(1'b0, 2'h1, 2 * t, t + 4);
            chk(32'(o_pm.clk_slow), 32'h1);
            chk(32'(o_pm.slow_ratio), 32'h6);
            chk(32'(o_pm.save_type), 32'h3);
            chk(32'(o_pm.video), 32'h0);
            wait_st(1'b0, 2'h2, t, t + 4);
            chk(32'(o_pm.monitor), 32'h3);
            chk(32'(o_pm.video), 32'h2);
            pulse(11'h200);
            chk(32'(o_pm.pstate), 32'h0);
            chk({31'h0, o_irq}, 32'h1);
            apb(1'b0, ipm_pkg::OFS_EVT, 32'h0);
            #1;
            chk(rd_data, 32'h0000_0007);
            chk({31'h0, o_irq}, 32'h0);
            chk(32'(o_pm.clk_slow), 32'h0);
        end
        apb(1'b1, ipm_pkg::OFS_DEVMON, 32'h0000_01FF);
        apb(1'b0, ipm_pkg::OFS_DEVMON, 32'h0);
        chk(rd_data, {23'h0, ipm_pkg::DEVMON_VALID});
        apb(1'b1, ipm_pkg::OFS_DEVMON, 32'h0000_0001);
        apb(1'b1, ipm_pkg::OFS_TIMEOUT, 32'h0000_0002);
        c.disp_mon = 1'b0;
        c.unit = ipm_pkg::IPM_UNIT_4MS;
        apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
        pulse(11'h001);
        wait_st(1'b0, 2'h1, 8, 8);
        pulse(11'h200);
        pulse(11'h020);
        repeat (20) @(posedge i_clock);
        #1;
        chk(32'(o_pm.pstate), 32'h1);
        pulse(11'h001);
        chk(32'(o_pm.pstate), 32'h0);
        c.hdd_mode = ipm_pkg::IPM_LP_STANDBY;
        c.hdd_timeout = 4'h1;
        apb(1'b1, ipm_pkg::OFS_TIMEOUT, 32'h0);
        apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
        pulse(11'h001);
        wait_st(1'b1, 2'h1, 12, 16);
        chk(32'(o_pm.pstate), 32'h0);
        c.button_suspend = 1'b1;
        apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
        for (int b = 0; b < 4; b++) begin
            if (b == 2) begin
                c.button_suspend = 1'b0;
                apb(1'b1, ipm_pkg::OFS_CTRL, {11'h000, c});
            end
            pulse(11'h400);
            chk(32'(o_pm.pstate), (b % 2) ? 32'h0 : ((b < 2) ? 32'h2 : 32'h3));
        end
        apb(1'b0, ipm_pkg::OFS_EVT, 32'h0);
        chk(rd_data & 32'h18, 32'h18);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
